// >>> pkg/ssc_pkg.sv
// Summary of operation
// - Bit 15 enables step, resets zero.
// - Gain code 00=1, 01=2, 1x=4.
// - Bit 4 picks ground or input seven.
// - Codes 0000-0111 pick external inputs zero-seven.
// - Automatic codes ignore the negative-input bit.
// - Code 1001 shorts converter to ground.
// - Positive field resets 1001, rest zero.
package ssc_pkg;
  localparam logic [3:0] SETUP_OFFSET = 4'h0;
  localparam int ENABLE_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic NEG_RESET = 1'h0;
  localparam logic [3:0] POS_RESET = 4'h9;
  localparam logic [3:0] POS_LAST_EXTERNAL = 4'h7;
  localparam logic [3:0] POS_GROUND_SHORT = 4'h9;
  localparam logic [2:0] GAIN_X1 = 3'h1;
  localparam logic [2:0] GAIN_X2 = 3'h2;
  localparam logic [2:0] GAIN_X4 = 3'h4;
endpackage

// >>> verilog/ssc_decode.sv
`timescale 1ns/10ps
module ssc_decode (
  input wire logic [1:0] gain_code_i,
  input wire logic neg_sel_i,
  input wire logic [3:0] pos_sel_i,
  output logic [2:0] gain_factor_o,
  output logic neg_is_input_seven_o,
  output logic neg_automatic_o,
  output logic pos_external_o,
  output logic ground_short_o
);
  always_comb begin
    unique case (gain_code_i)
      2'h0: gain_factor_o = ssc_pkg::GAIN_X1;
      2'h1: gain_factor_o = ssc_pkg::GAIN_X2;
      2'h2, 2'h3: gain_factor_o = ssc_pkg::GAIN_X4;
    endcase
  end
  // Codes above the last external input pick internal sources with automatic negative input.
  assign neg_automatic_o = pos_sel_i > ssc_pkg::POS_LAST_EXTERNAL;
  assign pos_external_o = pos_sel_i <= ssc_pkg::POS_LAST_EXTERNAL;
  assign neg_is_input_seven_o = neg_sel_i && !neg_automatic_o;
  assign ground_short_o = pos_sel_i == ssc_pkg::POS_GROUND_SHORT;
endmodule

// >>> verilog/ssc_step_nine.sv
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
module ssc_step_nine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [1:0] wb_sel_i,
  input wire logic [15:0] wb_dat_i,
  output logic [15:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic step_nine_enable_o,
  output logic [1:0] step_nine_gain_select_o,
  output logic [2:0] gain_factor_o,
  output logic step_nine_negative_input_o,
  output logic neg_is_input_seven_o,
  output logic neg_automatic_o,
  output logic [3:0] step_nine_positive_input_o,
  output logic pos_external_o,
  output logic ground_short_o
);
  // Bits that belong to a defined field; every other bit of the word reads as zero.
  localparam logic [15:0] FIELD_MASK = (16'h0001 << ssc_pkg::ENABLE_BIT) |
    (16'h0003 << ssc_pkg::GAIN_LO) |
    (16'h0001 << ssc_pkg::NEG_BIT) |
    (16'h000F << ssc_pkg::POS_LO);

  // Bus handshake.
  logic ack_q;
  logic err_q;
  logic req;
  logic hit;
  logic wr_take;
  logic rd_take;
  logic lane_hi_we;
  logic lane_lo_we;
  wire logic [15:0] wr_bit;

  // Field registers and the values they take at the next edge.
  logic en_q;
  logic en_d;
  logic [1:0] gain_q;
  logic [1:0] gain_d;
  logic neg_q;
  logic neg_d;
  logic [3:0] pos_q;
  logic [3:0] pos_d;

  // Decoded views of the fields.
  logic [2:0] gain_factor_d;
  logic [2:0] gain_factor_q;
  logic neg_seven_d;
  logic neg_seven_q;
  logic neg_auto_d;
  logic neg_auto_q;
  logic pos_ext_d;
  logic pos_ext_q;
  logic short_d;
  logic short_q;

  // Read path.
  logic [15:0] field_word;
  wire logic [15:0] rd_d;
  logic [15:0] rd_q;

  // A request is taken only while no answer is pending, so a strobe held high after ack is answered
  // every other cycle and writes the register again with each answer.
  assign req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign hit = wb_adr_i == ssc_pkg::SETUP_OFFSET;
  assign wr_take = req && hit && wb_we_i;
  assign rd_take = req && hit && !wb_we_i;
  assign lane_hi_we = wr_take && wb_sel_i[1];
  assign lane_lo_we = wr_take && wb_sel_i[0];

  // Each bit follows the byte lane it sits in, so moving a field never needs a second edit here.
  for (genvar b = 0; b < 16; b++) begin : g_wr_bit
    assign wr_bit[b] = (b >= 8) ? lane_hi_we : lane_lo_we;
  end

  // Ack stands for exactly one cycle; the next request can be taken in the cycle after it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && hit;
    end
  end

  // An unmapped address is answered with err so that a stray access cannot hang the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
    end else begin
      err_q <= req && !hit;
    end
  end

  // Reset is folded into the next values so that the fields and their decoded views leave reset together.
  always_comb begin
    en_d = en_q;
    if (rst_i) begin
      en_d = ssc_pkg::ENABLE_RESET;
    end else if (wr_bit[ssc_pkg::ENABLE_BIT]) begin
      en_d = wb_dat_i[ssc_pkg::ENABLE_BIT];
    end
  end

  always_comb begin
    gain_d = gain_q;
    if (rst_i) begin
      gain_d = ssc_pkg::GAIN_RESET;
    end else if (wr_bit[ssc_pkg::GAIN_HI]) begin
      gain_d = wb_dat_i[ssc_pkg::GAIN_HI:ssc_pkg::GAIN_LO];
    end
  end

  always_comb begin
    neg_d = neg_q;
    if (rst_i) begin
      neg_d = ssc_pkg::NEG_RESET;
    end else if (wr_bit[ssc_pkg::NEG_BIT]) begin
      neg_d = wb_dat_i[ssc_pkg::NEG_BIT];
    end
  end

  always_comb begin
    pos_d = pos_q;
    if (rst_i) begin
      pos_d = ssc_pkg::POS_RESET;
    end else if (wr_bit[ssc_pkg::POS_LO]) begin
      pos_d = wb_dat_i[ssc_pkg::POS_HI:ssc_pkg::POS_LO];
    end
  end

  // No reset branch is needed below: the next values already carry the reset.
  always_ff @(posedge clk_i) begin
    en_q <= en_d;
  end

  always_ff @(posedge clk_i) begin
    gain_q <= gain_d;
  end

  always_ff @(posedge clk_i) begin
    neg_q <= neg_d;
  end

  always_ff @(posedge clk_i) begin
    pos_q <= pos_d;
  end

  // The decoder sees the next field values, so its registered outputs never lag the fields by a cycle.
  ssc_decode u_decode (
    .gain_code_i(gain_d),
    .neg_sel_i(neg_d),
    .pos_sel_i(pos_d),
    .gain_factor_o(gain_factor_d),
    .neg_is_input_seven_o(neg_seven_d),
    .neg_automatic_o(neg_auto_d),
    .pos_external_o(pos_ext_d),
    .ground_short_o(short_d)
  );

  always_ff @(posedge clk_i) begin
    gain_factor_q <= gain_factor_d;
  end

  always_ff @(posedge clk_i) begin
    neg_seven_q <= neg_seven_d;
  end

  always_ff @(posedge clk_i) begin
    neg_auto_q <= neg_auto_d;
  end

  always_ff @(posedge clk_i) begin
    pos_ext_q <= pos_ext_d;
  end

  always_ff @(posedge clk_i) begin
    short_q <= short_d;
  end

  // The word as stored, before reserved bits are masked.
  always_comb begin
    field_word = 16'h0000;
    field_word[ssc_pkg::ENABLE_BIT] = en_q;
    field_word[ssc_pkg::GAIN_HI:ssc_pkg::GAIN_LO] = gain_q;
    field_word[ssc_pkg::NEG_BIT] = neg_q;
    field_word[ssc_pkg::POS_HI:ssc_pkg::POS_LO] = pos_q;
  end

  // Masking bit by bit keeps reserved bits low even if a field position changes.
  for (genvar b = 0; b < 16; b++) begin : g_rd_bit
    assign rd_d[b] = FIELD_MASK[b] && field_word[b];
  end

  // Read data is zero on writes and errors, so the bus never shows a value it was not asked for.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= 16'h0000;
    end else if (req) begin
      rd_q <= rd_take ? rd_d : 16'h0000;
    end
  end

  // Every data output below comes straight from a flip-flop.
  assign wb_dat_o = rd_q;
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign step_nine_enable_o = en_q;
  assign step_nine_gain_select_o = gain_q;
  assign step_nine_negative_input_o = neg_q;
  assign step_nine_positive_input_o = pos_q;
  assign gain_factor_o = gain_factor_q;
  assign neg_is_input_seven_o = neg_seven_q;
  assign neg_automatic_o = neg_auto_q;
  assign pos_external_o = pos_ext_q;
  assign ground_short_o = short_q;
endmodule

// >>> bench/ssc_step_nine_properties.sv
`timescale 1ns/10ps
module ssc_step_nine_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [1:0] wb_sel_i,
  input wire logic [15:0] wb_dat_i,
  input wire logic [15:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic step_nine_enable_o,
  input wire logic [1:0] step_nine_gain_select_o,
  input wire logic [2:0] gain_factor_o,
  input wire logic [3:0] step_nine_positive_input_o,
  input wire logic neg_automatic_o,
  input wire logic ground_short_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h0 && !wb_ack_o && !wb_err_o;
  AST_EN_WR: assert property (wr && wb_sel_i[1] |=>
    step_nine_enable_o == $past(wb_dat_i[15])) else $error("en");
  AST_EN_RST: assert property ($past(rst_i) |-> !step_nine_enable_o) else $error("en rst");
  AST_GAIN: assert property (gain_factor_o == (step_nine_gain_select_o == 2'h0 ? 3'h1 :
    step_nine_gain_select_o == 2'h1 ? 3'h2 : 3'h4)) else $error("gain");
  AST_POS_WR: assert property (wr && wb_sel_i[0] |=>
    step_nine_positive_input_o == $past(wb_dat_i[3:0])) else $error("pos");
  AST_AUTO: assert property (neg_automatic_o == step_nine_positive_input_o[3]) else $error("auto");
  AST_SHORT: assert property (ground_short_o == (step_nine_positive_input_o == 4'h9)) else $error("short");
  AST_POS_RST: assert property ($past(rst_i) |-> step_nine_positive_input_o == 4'h9) else $error("pos rst");
  AST_RSVD: assert property (wb_ack_o |-> wb_dat_o[12:5] == 8'h00) else $error("rsvd");
endmodule
bind ssc_step_nine ssc_step_nine_properties u_ssc_step_nine_properties (.*);

// >>> bench/tb_ssc_step_nine.sv
`timescale 1ns/10ps
module tb_ssc_step_nine;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, er;
  logic [3:0] wb_adr_i = 4'h0;
  logic [1:0] wb_sel_i = 2'h0;
  logic [15:0] wb_dat_i = 16'h0, rd;
  logic [15:0] wb_dat_o;
  logic wb_ack_o, wb_err_o, step_nine_enable_o, step_nine_negative_input_o, neg_is_input_seven_o;
  logic neg_automatic_o, pos_external_o, ground_short_o;
  logic [1:0] step_nine_gain_select_o;
  logic [2:0] gain_factor_o;
  logic [3:0] step_nine_positive_input_o;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  logic [36:0] rows [4] = '{{16'h7FFF, 16'h601F, 5'h0C}, {16'hFFF0, 16'hE010, 5'h14},
    {16'h2006, 16'h2006, 5'h02}, {16'h0019, 16'h0019, 5'h09}};
  ssc_step_nine u_ssc_step_nine (.*);
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 2000) begin n_mismatch++; close_out; end
  task bus(input logic w, input logic [3:0] a, input logic [1:0] s, input logic [15:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, d};
    do @(posedge clk_i); while (!(wb_ack_o | wb_err_o));
    rd = wb_dat_o;
    er = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
  endtask
  task close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h0, 2'h3, 16'h0);
    chk(rd, 16'h0009);
    chk({ground_short_o, gain_factor_o}, 16'h9);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1, 4'h0, 2'h3, rows[i][36:21]);
      bus(0, 4'h0, 2'h3, 16'h0);
      chk(rd, rows[i][20:5]);
      chk({neg_is_input_seven_o, neg_automatic_o, gain_factor_o}, rows[i][4:0]);
      chk({step_nine_enable_o, step_nine_gain_select_o, step_nine_negative_input_o,
        step_nine_positive_input_o, pos_external_o}, {rows[i][20:18], rows[i][9:5], rows[i][8:5] < 4'h8});
      $display("row %0d done", i);
    end
    bus(1, 4'h0, 2'h1, 16'hFFF7);
    bus(1, 4'h2, 2'h3, 16'hFFFF);
    chk(er, 1'h1);
    bus(0, 4'h0, 2'h3, 16'h0);
    chk(rd, 16'h0017);
    chk(neg_is_input_seven_o, 1'h1);
    $display("lane and error test done");
    bus(1, 4'h0, 2'h2, 16'hFFFF);
    bus(0, 4'h0, 2'h3, 16'h0);
    chk(rd, 16'hE017);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 4'h0, 2'h3, 16'h0);
    chk(rd, 16'h0009);
    chk({step_nine_enable_o, ground_short_o, neg_automatic_o}, 3'h3);
    $display("mid-run reset test done");
    close_out;
  end
endmodule
